// ===== rtl/adc_ctl_pkg.sv
/*
  constants, field layout and carrier types for the converter start and
  window detector control block.
  assumes an 8-bit special-function-register bus and a converter core on
  the same system clock.
*/
package adc_ctl_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL    = 8'hE8;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'hC4;
  localparam logic [7:0] ADDR_UPPER_LOW  = 8'hC3;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'hC6;
  localparam logic [7:0] ADDR_LOWER_LOW  = 8'hC5;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE = 7;
  localparam int BIT_TRACK  = 6;
  localparam int BIT_DONE   = 5;
  localparam int BIT_BUSY   = 4;
  localparam int BIT_WINDOW = 3;
  localparam int CM_MSB     = 2;
  localparam int CM_LSB     = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] UPPER_HIGH_RESET = 8'hFF;
  localparam logic [7:0] UPPER_LOW_RESET  = 8'hFF;
  localparam logic [7:0] LOWER_HIGH_RESET = 8'h00;
  localparam logic [7:0] LOWER_LOW_RESET  = 8'h00;

  // ---------------------------------------------------------------
  // start source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CM_SOFTWARE = 3'h0;
  localparam logic [2:0] CM_TIMER2   = 3'h2;
  localparam logic [2:0] CM_TIMER1   = 3'h3;
  localparam logic [2:0] CM_EXT_PIN  = 3'h4;
  localparam logic [2:0] CM_TIMER5   = 3'h7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int TRACK_SAR_CLOCKS = 3;
  localparam int SAR_DIV_DEFAULT  = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_TRACK   = 2'h1,
    ST_CONVERT = 2'h3
  } conv_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic        done;
    logic [15:0] word;
  } conv_result_t;

  typedef struct packed {
    logic tmr2;
    logic tmr1;
    logic tmr5;
  } timer_ovf_t;

endpackage : adc_ctl_pkg

// ===== rtl/window_compare.sv
/*
  window comparison of one converter result against two 16-bit limits.
  assumes the result word is already in its current justification.
*/
`timescale 1ns/100ps

module window_compare (
  input  wire logic [15:0] result_word,
  input  wire logic [15:0] upper_limit,
  input  wire logic [15:0] lower_limit,
  output logic             in_match
);

  // ---------------------------------------------------------------
  // inside or outside chosen by the limits alone
  // ---------------------------------------------------------------
  always_comb begin
    if (lower_limit > upper_limit) begin
      in_match = (result_word > upper_limit) && (result_word < lower_limit);
    end else begin
      in_match = (result_word < lower_limit) || (result_word > upper_limit);
    end
  end

endmodule : window_compare

// ===== rtl/adc_start_window.sv
/*
  converter start control, busy indication and programmable window detector,
  reached over the special-function-register bus.
  assumes timer overflows and the converter core run on ref_clk; the
  external start pin is asynchronous.
*/
`timescale 1ns/100ps

// Functional notes
// - writing one to busy starts a conversion only with start source zero.
// - busy reads one while a start is tracking or converting, zero otherwise.
// - window flag at control bit 3 sets on match, holds until cleared.
// - start codes 010, 011, 111 pick timer 2, 1, 5 overflow.
// - results are compared to the limits continuously without software.
// - window flag drives an interrupt request and is readable for polling.
// - limits are two 16-bit values, each from high and low bytes.
// - inside or outside is chosen only by the two limit values.
// - upper limit high byte is read/write and resets to all ones.
// - lower above upper flags between; otherwise flags below lower or above upper.
// - external pin start (code 100) skips the extra tracking delay.
// - delayed track mode tracks three extra converter clocks before converting.
module adc_start_window
  import adc_ctl_pkg::*;
#(
  parameter int SAR_DIV = adc_ctl_pkg::SAR_DIV_DEFAULT
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire adc_ctl_pkg::sfr_req_t     sfr,
  output logic [7:0]                     sfr_rdata,
  input  wire adc_ctl_pkg::timer_ovf_t   timer_ovf,
  input  wire logic                      external_start_pin,
  input  wire adc_ctl_pkg::conv_result_t conv,
  output logic                           conv_enable,
  output logic                           conv_start,
  output logic                           conversion_busy,
  output logic                           window_match_flag
);

  // ---------------------------------------------------------------
  // derived counts and parameter checks
  // ---------------------------------------------------------------
  localparam int         TRACK_CYCLES = TRACK_SAR_CLOCKS * SAR_DIV;
  localparam logic [7:0] TRACK_LOAD   = 8'(TRACK_CYCLES - 1);

  if (SAR_DIV < 1 || TRACK_CYCLES > 256) begin : g_param_check
    $error("SAR_DIV out of range");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        enable;
    logic        track_mode;
    logic        done_flag;
    logic        window_flag;
    logic [2:0]  cm;
    logic [7:0]  upper_high;
    logic [7:0]  upper_low;
    logic [7:0]  lower_high;
    logic [7:0]  lower_low;
    conv_state_t state;
    logic [7:0]  track_cnt;
    logic [2:0]  pin_sync;
    logic        busy;
    logic        conv_start;
    logic [7:0]  rdata;
  } state_t;

  state_t s_ff;
  state_t nxt_s;
  logic   win_match;
  logic   wr_ctrl;
  logic   sw_start;
  logic   trig;
  logic   pin_edge;
  logic   start_evt;
  logic   conv_done;

  window_compare u_window (
    .result_word (conv.word),
    .upper_limit ({s_ff.upper_high, s_ff.upper_low}),
    .lower_limit ({s_ff.lower_high, s_ff.lower_low}),
    .in_match    (win_match)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s            = s_ff;
    nxt_s.conv_start = 1'b0;
    nxt_s.rdata      = 8'h00;
    nxt_s.pin_sync   = {s_ff.pin_sync[1:0], external_start_pin};
    pin_edge         = s_ff.pin_sync[1] & ~s_ff.pin_sync[2];
    wr_ctrl          = sfr.wr && (sfr.addr == ADDR_CONTROL);
    sw_start         = wr_ctrl && sfr.wdata[BIT_BUSY]
                       && (sfr.wdata[CM_MSB:CM_LSB] == CM_SOFTWARE);
    conv_done        = conv.done && (s_ff.state == ST_CONVERT);

    case (s_ff.cm)
      CM_TIMER2:  trig = timer_ovf.tmr2;
      CM_TIMER1:  trig = timer_ovf.tmr1;
      CM_TIMER5:  trig = timer_ovf.tmr5;
      CM_EXT_PIN: trig = pin_edge;
      default:    trig = 1'b0;
    endcase
    start_evt = s_ff.enable && (s_ff.state == ST_IDLE) && (sw_start || trig);

    // register writes
    if (sfr.wr) begin
      case (sfr.addr)
        ADDR_CONTROL: begin
          nxt_s.enable      = sfr.wdata[BIT_ENABLE];
          nxt_s.track_mode  = sfr.wdata[BIT_TRACK];
          nxt_s.done_flag   = sfr.wdata[BIT_DONE];
          nxt_s.window_flag = sfr.wdata[BIT_WINDOW];
          nxt_s.cm          = sfr.wdata[CM_MSB:CM_LSB];
        end
        ADDR_UPPER_HIGH: nxt_s.upper_high = sfr.wdata;
        ADDR_UPPER_LOW:  nxt_s.upper_low  = sfr.wdata;
        ADDR_LOWER_HIGH: nxt_s.lower_high = sfr.wdata;
        ADDR_LOWER_LOW:  nxt_s.lower_low  = sfr.wdata;
        default: ;
      endcase
    end

    // conversion sequencing
    case (s_ff.state)
      ST_IDLE: begin
        if (start_evt) begin
          if (s_ff.track_mode && (s_ff.cm != CM_EXT_PIN)) begin
            nxt_s.state     = ST_TRACK;
            nxt_s.track_cnt = TRACK_LOAD;
          end else begin
            nxt_s.state      = ST_CONVERT;
            nxt_s.conv_start = 1'b1;
          end
        end
      end
      ST_TRACK: begin
        if (s_ff.track_cnt == 8'h00) begin
          nxt_s.state      = ST_CONVERT;
          nxt_s.conv_start = 1'b1;
        end else begin
          nxt_s.track_cnt = s_ff.track_cnt - 8'h01;
        end
      end
      ST_CONVERT: begin
        if (conv.done) begin
          nxt_s.state = ST_IDLE;
        end
      end
      default: nxt_s.state = ST_IDLE;
    endcase
    if (!nxt_s.enable) begin
      nxt_s.state = ST_IDLE;
    end
    nxt_s.busy = (nxt_s.state != ST_IDLE);

    // hardware sets win over software clears
    if (conv_done) begin
      nxt_s.done_flag = 1'b1;
      if (win_match) begin
        nxt_s.window_flag = 1'b1;
      end
    end

    // register reads, answered one cycle after the strobe
    if (sfr.rd) begin
      case (sfr.addr)
        ADDR_CONTROL:    nxt_s.rdata = {s_ff.enable, s_ff.track_mode, s_ff.done_flag,
                                        s_ff.busy, s_ff.window_flag, s_ff.cm};
        ADDR_UPPER_HIGH: nxt_s.rdata = s_ff.upper_high;
        ADDR_UPPER_LOW:  nxt_s.rdata = s_ff.upper_low;
        ADDR_LOWER_HIGH: nxt_s.rdata = s_ff.lower_high;
        ADDR_LOWER_LOW:  nxt_s.rdata = s_ff.lower_low;
        default:         nxt_s.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff.enable      <= CONTROL_RESET[BIT_ENABLE];
      s_ff.track_mode  <= CONTROL_RESET[BIT_TRACK];
      s_ff.done_flag   <= CONTROL_RESET[BIT_DONE];
      s_ff.window_flag <= CONTROL_RESET[BIT_WINDOW];
      s_ff.cm          <= CONTROL_RESET[CM_MSB:CM_LSB];
      s_ff.upper_high  <= UPPER_HIGH_RESET;
      s_ff.upper_low   <= UPPER_LOW_RESET;
      s_ff.lower_high  <= LOWER_HIGH_RESET;
      s_ff.lower_low   <= LOWER_LOW_RESET;
      s_ff.state       <= ST_IDLE;
      s_ff.track_cnt   <= 8'h00;
      s_ff.pin_sync    <= 3'h0;
      s_ff.busy        <= 1'b0;
      s_ff.conv_start  <= 1'b0;
      s_ff.rdata       <= 8'h00;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sfr_rdata         = s_ff.rdata;
  assign conv_enable       = s_ff.enable;
  assign conv_start        = s_ff.conv_start;
  assign conversion_busy   = s_ff.busy;
  assign window_match_flag = s_ff.window_flag;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  localparam int TRK_DLY = TRACK_CYCLES;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence idle_ready;
    s_ff.enable && (s_ff.state == ST_IDLE) && !(sfr.wr && sfr.addr == ADDR_CONTROL);
  endsequence

  sequence delayed_timer_start;
    idle_ready and (s_ff.track_mode && s_ff.cm == CM_TIMER1 && timer_ovf.tmr1);
  endsequence

  sequence ext_pin_start;
    idle_ready and (s_ff.cm == CM_EXT_PIN && pin_edge);
  endsequence

  a_sw_start_ok: assert property (
    (wr_ctrl && sfr.wdata[BIT_BUSY] && sfr.wdata[BIT_ENABLE] && s_ff.enable
     && sfr.wdata[CM_MSB:CM_LSB] == CM_SOFTWARE && s_ff.state == ST_IDLE) |=> conversion_busy)
    else $error("software start did not set busy");

  a_sw_start_ignored: assert property (
    (wr_ctrl && sfr.wdata[BIT_BUSY] && sfr.wdata[CM_MSB:CM_LSB] != CM_SOFTWARE
     && s_ff.state == ST_IDLE && !trig) |=> !conversion_busy)
    else $error("busy write started with nonzero source");

  a_busy_clears: assert property (
    (s_ff.state == ST_CONVERT && conv.done) |=> !conversion_busy)
    else $error("busy stayed high after conversion end");

  a_flag_sticky: assert property (
    (window_match_flag && !(wr_ctrl && !sfr.wdata[BIT_WINDOW])) |=> window_match_flag)
    else $error("window flag dropped without clear");

  a_timer2_start: assert property (
    (idle_ready and (!s_ff.track_mode && s_ff.cm == CM_TIMER2 && timer_ovf.tmr2))
    |=> conv_start && conversion_busy)
    else $error("timer 2 overflow did not start");

  a_match_sets_flag: assert property (
    (conv_done && win_match) |=> window_match_flag)
    else $error("match did not set window flag");

  a_no_match_clear: assert property (
    (conv_done && !win_match && !window_match_flag && !wr_ctrl) |=> !window_match_flag)
    else $error("window flag set without match");

  a_poll_reads_flag: assert property (
    (sfr.rd && sfr.addr == ADDR_CONTROL) |=> sfr_rdata[BIT_WINDOW] == $past(s_ff.window_flag))
    else $error("polled flag differs from flag");

  a_upper_reset: assert property (
    $rose(rst_n) |-> s_ff.upper_high == UPPER_HIGH_RESET)
    else $error("upper high byte not all ones after reset");

  a_inside_window: assert property (
    (conv_done && {s_ff.lower_high, s_ff.lower_low} > {s_ff.upper_high, s_ff.upper_low}
     && conv.word > {s_ff.upper_high, s_ff.upper_low}
     && conv.word < {s_ff.lower_high, s_ff.lower_low}) |=> window_match_flag)
    else $error("inside result not flagged");

  a_ext_no_delay: assert property (
    ext_pin_start |=> conv_start && s_ff.state == ST_CONVERT)
    else $error("pin start was delayed");

  a_track_hold: assert property (
    delayed_timer_start |=> (s_ff.state == ST_TRACK && !conv_start) [*3])
    else $error("tracking delay too short");

  a_track_end: assert property (
    delayed_timer_start ##1 (s_ff.enable [*1]) |-> ##[TRK_DLY:TRK_DLY] conv_start)
    else $error("conversion did not begin after tracking");

endmodule : adc_start_window

// ===== verification/conv_core_model.sv
/*
  converter core stand-in: answers each start pulse with one result.
  assumes conv_start is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/100ps

module conv_core_model #(
  parameter int LAT = 5
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 conv_start,
  input  wire logic [15:0]          next_word,
  output adc_ctl_pkg::conv_result_t conv
);
  import adc_ctl_pkg::*;
  int cnt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 0;
      conv <= '0;
    end else begin
      if (conv_start) begin
        cnt  <= LAT;
        conv <= '{done: 1'b0, word: ~conv.word};
      end else if (cnt == 1) begin
        cnt  <= 0;
        conv <= '{done: 1'b1, word: next_word};
      end else begin
        cnt  <= (cnt > 1) ? cnt - 1 : 0;
        // word is only valid with done, so it toggles in between
        conv <= '{done: 1'b0, word: ~conv.word};
      end
    end
  end
endmodule : conv_core_model

// ===== verification/adc_start_window_tb_top.sv
/*
  self-checking bench for the converter start and window detector block.
  assumes the converter core stand-in from conv_core_model.
*/
`timescale 1ns/100ps

module adc_start_window_tb_top;
  import adc_ctl_pkg::*;
  localparam int DIV = 2;
  logic         ref_clk = 0;
  logic         rst_n = 0;
  sfr_req_t     sfr = '0;
  timer_ovf_t   timer_ovf = '0;
  logic         external_start_pin = 0;
  logic [15:0]  next_word = 16'h0000;
  conv_result_t conv;
  logic [7:0]   sfr_rdata;
  logic         conv_enable, conv_start, conversion_busy, window_match_flag;
  int           fails = 0, samples_checked = 0, cyc = 0, starts = 0;
  int           start_cyc, busy_cyc;
  logic         busy_q = 0;

  adc_start_window #(.SAR_DIV(DIV)) i_adc_start_window (
    .ref_clk(ref_clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .timer_ovf(timer_ovf), .external_start_pin(external_start_pin), .conv(conv),
    .conv_enable(conv_enable), .conv_start(conv_start),
    .conversion_busy(conversion_busy), .window_match_flag(window_match_flag));

  conv_core_model i_conv_core_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .conv_start(conv_start),
    .next_word(next_word), .conv(conv));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (conv_start === 1'b1) begin
      starts++;
      start_cyc = cyc;
    end
    if (conversion_busy === 1'b1 && busy_q !== 1'b1) busy_cyc = cyc;
    busy_q = conversion_busy;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  task automatic check_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_cnt

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask : check1

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    tick();
    sfr.wr = 1'b0;
    tick();
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    sfr.addr = a;
    sfr.rd = 1'b1;
    tick();
    sfr.rd = 1'b0;
    d = sfr_rdata;
    tick();
  endtask : reg_rd

  task automatic wait_idle();
    for (int i = 0; i < 60 && conversion_busy !== 1'b0; i++) tick();
    check1(conversion_busy, 1'b0);
  endtask : wait_idle

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] a[6] = '{8'hE8, 8'hC4, 8'hC3, 8'hC6, 8'hC5, 8'h10};
    logic [7:0] e[6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    check1(conv_enable, 1'b0);
    for (int i = 0; i < 6; i++) begin
      reg_rd(a[i], d);
      check8(d, e[i]);
    end
    reg_wr(8'hC4, 8'h12);
    reg_rd(8'hC4, d);
    check8(d, 8'h12);
  endtask : t_regs

  task automatic t_sw_start();
    int s0;
    s0 = starts;
    reg_wr(8'hE8, 8'h80);
    check1(conv_enable, 1'b1);
    reg_wr(8'hE8, 8'h92);
    check1(conversion_busy, 1'b0);
    reg_wr(8'hE8, 8'h80);
    check_cnt(starts - s0, 0);
    reg_wr(8'hE8, 8'h90);
    check1(conversion_busy, 1'b1);
    wait_idle();
    check_cnt(starts - s0, 1);
    check_cnt(start_cyc - busy_cyc, 0);
  endtask : t_sw_start

  task automatic t_timers();
    logic [2:0] code[4] = '{3'h2, 3'h3, 3'h7, 3'h1};
    timer_ovf_t hit[4] = '{3'b100, 3'b010, 3'b001, 3'b111};
    int s0;
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'hE8, {5'b10000, code[i]});
      s0 = starts;
      timer_ovf = ~hit[i];
      tick();
      timer_ovf = '0;
      wait_idle();
      check_cnt(starts - s0, 0);
      timer_ovf = hit[i];
      tick();
      timer_ovf = '0;
      tick();
      wait_idle();
      check_cnt(starts - s0, (i < 3) ? 1 : 0);
    end
  endtask : t_timers

  task automatic t_window();
    logic [15:0] lo[6] = '{16'h0080, 16'h0080, 16'h0080, 16'h0040, 16'h0040, 16'h0040};
    logic [15:0] hi[6] = '{16'h0040, 16'h0040, 16'h0040, 16'h0080, 16'h0080, 16'h0080};
    logic [15:0] w[6]  = '{16'h0060, 16'h0040, 16'h0080, 16'h0030, 16'h0080, 16'h0081};
    logic        m[6]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0]  d;
    for (int i = 0; i < 6; i++) begin
      reg_wr(8'hC6, lo[i][15:8]);
      reg_wr(8'hC5, lo[i][7:0]);
      reg_wr(8'hC4, hi[i][15:8]);
      reg_wr(8'hC3, hi[i][7:0]);
      reg_wr(8'hE8, 8'h80);
      next_word = w[i];
      reg_wr(8'hE8, 8'h90);
      wait_idle();
      check1(window_match_flag, m[i]);
      reg_rd(8'hE8, d);
      check8(d, {4'hA, m[i], 3'h0});
      if (m[i]) begin
        next_word = lo[i];
        reg_wr(8'hE8, 8'hB8);
        wait_idle();
        check1(window_match_flag, 1'b1);
        reg_wr(8'hE8, 8'h80);
        check1(window_match_flag, 1'b0);
      end
    end
  endtask : t_window

  task automatic t_track();
    logic [7:0] d;
    reg_wr(8'hE8, 8'hC0);
    reg_wr(8'hE8, 8'hD0);
    reg_rd(8'hE8, d);
    check8(d, 8'hD0);
    wait_idle();
    check_cnt(start_cyc - busy_cyc, 3 * DIV);
    // delayed tracking also applies to a timer start
    reg_wr(8'hE8, 8'hC3);
    timer_ovf.tmr1 = 1'b1;
    tick();
    timer_ovf = '0;
    wait_idle();
    check_cnt(start_cyc - busy_cyc, 3 * DIV);
    reg_wr(8'hE8, 8'hC4);
    external_start_pin = 1'b1;
    repeat (4) tick();
    wait_idle();
    check_cnt(start_cyc - busy_cyc, 0);
    check_cnt(int'(cyc - busy_cyc < 30), 1);
    external_start_pin = 1'b0;
    tick();
  endtask : t_track

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_sw_start();
    t_timers();
    t_window();
    t_track();
    wrap_up();
  end
endmodule : adc_start_window_tb_top
